// File: rtl/sbx_pkg.sv
// constants, opcode classes and helpers for the call/return/bit/mode-change executor
// assumes a single core clock; the RAM and special registers live outside the block
package sbx_pkg;
   localparam logic [7:0]  OP_NOP          = 8'h00;
   localparam logic [7:0]  OP_FAR_REL      = 8'h10;
   localparam logic [7:0]  OP_FAR_ABS      = 8'h20;
   localparam logic [7:0]  OP_RET          = 8'ha0;
   localparam logic [7:0]  OP_IRQ_RET      = 8'hb0;
   // mode-change opcode is not fixed by the core; default is arbitrary
   localparam logic [7:0]  OP_CHANGE_DEF   = 8'h01;
   localparam logic [7:0]  NEAR_MASK       = 8'he8;
   localparam logic [7:0]  NEAR_MATCH      = 8'h08;
   localparam logic [7:0]  BITOP_MASK      = 8'he8;
   localparam logic [7:0]  BIT_CLR_MATCH   = 8'hc8;
   localparam logic [7:0]  BIT_SET_MATCH   = 8'he8;
   localparam logic [7:0]  BIT_INV_MATCH   = 8'ha8;
   localparam int          ADDR_HI_BIT     = 4;
   localparam logic [15:0] PC_RESET        = 16'h0000;
   localparam logic [15:0] FLASH_ENTRY     = 16'h0000;
   localparam logic        FLASH_ENTRY_BNK = 1'b0;
   localparam logic [7:0]  SP_RESET        = 8'h00;
   localparam logic        ROM_MODE_RESET  = 1'b1;
   localparam logic [15:0] LEN_ONE         = 16'h0001;
   localparam logic [15:0] LEN_TWO         = 16'h0002;
   localparam logic [15:0] LEN_THREE       = 16'h0003;
   localparam logic [2:0]  CYC_ONE         = 3'h1;
   localparam logic [2:0]  CYC_TWO         = 3'h2;
   localparam logic [2:0]  CYC_FOUR        = 3'h4;

   typedef enum logic [3:0] {
      CL_NONE    = 4'h0,
      CL_NEAR    = 4'h1,
      CL_FAR_ABS = 4'h2,
      CL_FAR_REL = 4'h3,
      CL_RET     = 4'h4,
      CL_IRQ_RET = 4'h5,
      CL_BIT_CLR = 4'h6,
      CL_BIT_SET = 4'h7,
      CL_BIT_INV = 4'h8,
      CL_NOP     = 4'h9,
      CL_CHANGE  = 4'ha
   } sbx_class_t;

   // one-hot mask for the selected bit of a byte
   function automatic logic [7:0] sbx_bit_mask(input logic [2:0] idx);
      sbx_bit_mask = 8'h01 << idx;
   endfunction
endpackage

// File: rtl/sbx_decode.sv
// opcode decoder: class, byte count, cycle count and interrupt-window cycle
// assumes the first instruction byte is stable while it is read
`timescale 1ns/1ns
module sbx_decode
   import sbx_pkg::*;
#(
   parameter logic [7:0] CHANGE_OPCODE = OP_CHANGE_DEF
) (
   input  wire logic [7:0]  opcode,
   output sbx_class_t       opClass,
   output logic [15:0]      opLength,
   output logic [2:0]       opCycles,
   output logic [2:0]       irqCycle
);
   // irqCycle of zero means no interrupt window at all
   always_comb begin
      opClass  = CL_NONE;
      opLength = LEN_ONE;
      opCycles = CYC_ONE;
      irqCycle = 3'h0;
      if ((opcode & NEAR_MASK) == NEAR_MATCH) begin
         opClass  = CL_NEAR;
         opLength = LEN_TWO;
         opCycles = CYC_TWO;
         irqCycle = CYC_TWO;
      end else if (opcode == OP_FAR_ABS) begin
         opClass  = CL_FAR_ABS;
         opLength = LEN_THREE;
         opCycles = CYC_TWO;
         irqCycle = CYC_TWO;
      end else if (opcode == OP_FAR_REL) begin
         opClass  = CL_FAR_REL;
         opLength = LEN_THREE;
         opCycles = CYC_FOUR;
         irqCycle = CYC_FOUR;
      end else if (opcode == OP_RET) begin
         opClass  = CL_RET;
         opCycles = CYC_TWO;
         irqCycle = CYC_TWO;
      end else if (opcode == OP_IRQ_RET) begin
         opClass  = CL_IRQ_RET;
         opCycles = CYC_TWO;
      end else if ((opcode & BITOP_MASK) == BIT_CLR_MATCH) begin
         opClass  = CL_BIT_CLR;
         opLength = LEN_TWO;
         irqCycle = CYC_ONE;
      end else if ((opcode & BITOP_MASK) == BIT_SET_MATCH) begin
         opClass  = CL_BIT_SET;
         opLength = LEN_TWO;
         irqCycle = CYC_ONE;
      end else if ((opcode & BITOP_MASK) == BIT_INV_MATCH) begin
         opClass  = CL_BIT_INV;
         opLength = LEN_TWO;
         irqCycle = CYC_ONE;
      end else if (opcode == OP_NOP) begin
         opClass  = CL_NOP;
         irqCycle = CYC_ONE;
      end else if (opcode == CHANGE_OPCODE) begin
         opClass  = CL_CHANGE;
         opLength = LEN_THREE;
         opCycles = CYC_TWO;
      end
   end
endmodule

// File: rtl/sbx_stack.sv
// 8-bit stack pointer with push/pop stepping and an external load port
// assumes increment and decrement are never requested together
`timescale 1ns/1ns
module sbx_stack
   import sbx_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       spInc,
   input  wire logic       spDec,
   input  wire logic       spLoad,
   input  wire logic [7:0] spLoadValue,
   output logic [7:0]      stackPointer,
   output logic [7:0]      stackPointerUp
);
   logic [7:0] next_stackPointer;

   // wraps modulo 256 in both directions
   assign stackPointerUp = stackPointer + 8'h01;

   always_comb begin
      next_stackPointer = stackPointer;
      if (spInc) begin
         next_stackPointer = stackPointerUp;
      end else if (spDec) begin
         next_stackPointer = stackPointer - 8'h01;
      end else if (spLoad) begin
         next_stackPointer = spLoadValue;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stackPointer <= SP_RESET;
      end else begin
         stackPointer <= next_stackPointer;
      end
   end
endmodule

// File: rtl/subroutine_bit_ops_exec.sv
// executor for calls, returns, direct bit ops, no-op and program-mode change
// assumes same-clock fetch logic hands over all three bytes with execStart,
// and that the data RAM / special registers answer reads combinationally
`timescale 1ns/1ns
module subroutine_bit_ops_exec
   import sbx_pkg::*;
#(
   parameter logic [7:0] CHANGE_OPCODE = OP_CHANGE_DEF
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        execStart,
   input  wire logic [7:0]  instrByte0,
   input  wire logic [7:0]  instrByte1,
   input  wire logic [7:0]  instrByte2,
   input  wire logic        externalExecSelect,
   input  wire logic        irqTaken,
   input  wire logic        spLoad,
   input  wire logic [7:0]  spLoadValue,
   input  wire logic [7:0]  ramRdata,
   output logic             busy,
   output logic             execDone,
   output logic             illegalOp,
   output logic             irqWindow,
   output logic             irqEnabled,
   output logic [15:0]      programCounter,
   output logic [7:0]       stackPointer,
   output logic             romMode,
   output logic             flashBank,
   output logic [8:0]       ramAddr,
   output logic             ramRe,
   output logic             ramWe,
   output logic [7:0]       ramWdata
);
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } sbx_state_t;

   sbx_state_t  state;
   sbx_state_t  next_state;
   logic [2:0]  cycle;
   logic [2:0]  next_cycle;
   logic [7:0]  op0;
   logic [7:0]  op1;
   logic [7:0]  op2;
   logic [7:0]  next_op0;
   logic [7:0]  next_op1;
   logic [7:0]  next_op2;
   logic [15:0] next_programCounter;
   logic [7:0]  popHigh;
   logic [7:0]  next_popHigh;
   logic        next_romMode;
   logic        next_flashBank;
   logic        next_irqEnabled;
   sbx_class_t  opClass;
   logic [15:0] opLength;
   logic [2:0]  opCycles;
   logic [2:0]  irqCycle;
   logic        spInc;
   logic        spDec;
   logic [7:0]  stackPointerUp;
   logic [15:0] returnAddr;
   logic [7:0]  bitMask;
   logic        lastCycle;
   logic        accept;

   sbx_decode #(
      .CHANGE_OPCODE (CHANGE_OPCODE)
   ) sbx_decode_inst (
      .opcode   (op0),
      .opClass  (opClass),
      .opLength (opLength),
      .opCycles (opCycles),
      .irqCycle (irqCycle)
   );

   // stack pointer may also be written by software while idle
   sbx_stack sbx_stack_inst (
      .mclk           (mclk),
      .rst            (rst),
      .spInc          (spInc),
      .spDec          (spDec),
      .spLoad         (spLoad & ~busy),
      .spLoadValue    (spLoadValue),
      .stackPointer   (stackPointer),
      .stackPointerUp (stackPointerUp)
   );

   // handshake and per-cycle helpers
   assign busy       = (state == ST_RUN);
   assign accept     = (state == ST_IDLE) && execStart;
   assign lastCycle  = busy && (cycle == opCycles);
   assign execDone   = lastCycle;
   assign illegalOp  = lastCycle && (opClass == CL_NONE);
   assign irqWindow  = busy && (irqCycle != 3'h0) && (cycle == irqCycle);
   assign returnAddr = programCounter + opLength;
   assign bitMask    = sbx_bit_mask(op0[2:0]);

   // stack and RAM traffic per cycle
   always_comb begin
      spInc    = 1'b0;
      spDec    = 1'b0;
      ramAddr  = 9'h000;
      ramRe    = 1'b0;
      ramWe    = 1'b0;
      ramWdata = 8'h00;
      if (busy) begin
         unique case (opClass)
            CL_NEAR, CL_FAR_ABS, CL_FAR_REL: begin
               if (cycle <= CYC_TWO) begin
                  spInc    = 1'b1;
                  ramWe    = 1'b1;
                  ramAddr  = {1'b0, stackPointerUp};
                  ramWdata = (cycle == CYC_ONE) ? returnAddr[7:0] : returnAddr[15:8];
               end
            end
            CL_RET, CL_IRQ_RET: begin
               spDec   = 1'b1;
               ramRe   = 1'b1;
               ramAddr = {1'b0, stackPointer};
            end
            CL_BIT_CLR: begin
               ramRe    = 1'b1;
               ramWe    = 1'b1;
               ramAddr  = {op0[ADDR_HI_BIT], op1};
               ramWdata = ramRdata & ~bitMask;
            end
            CL_BIT_SET: begin
               ramRe    = 1'b1;
               ramWe    = 1'b1;
               ramAddr  = {op0[ADDR_HI_BIT], op1};
               ramWdata = ramRdata | bitMask;
            end
            CL_BIT_INV: begin
               ramRe    = 1'b1;
               ramWe    = 1'b1;
               ramAddr  = {op0[ADDR_HI_BIT], op1};
               ramWdata = ramRdata ^ bitMask;
            end
            CL_NOP, CL_CHANGE, CL_NONE: begin
               ramWe = 1'b0;
            end
            default: begin
               ramWe = 1'b0;
            end
         endcase
      end
   end

   // sequencer and instruction latch
   always_comb begin
      next_state = state;
      next_cycle = cycle;
      next_op0   = op0;
      next_op1   = op1;
      next_op2   = op2;
      if (accept) begin
         next_state = ST_RUN;
         next_cycle = CYC_ONE;
         next_op0   = instrByte0;
         next_op1   = instrByte1;
         next_op2   = instrByte2;
      end else if (lastCycle) begin
         next_state = ST_IDLE;
         next_cycle = 3'h0;
      end else if (busy) begin
         next_cycle = cycle + 3'h1;
      end
   end

   // program counter, popped byte, mode and interrupt enable
   always_comb begin
      next_programCounter = programCounter;
      next_popHigh        = popHigh;
      next_romMode        = romMode;
      next_flashBank      = flashBank;
      next_irqEnabled     = irqEnabled;
      if (irqTaken) begin
         next_irqEnabled = 1'b0;
      end
      if (busy && (opClass == CL_RET || opClass == CL_IRQ_RET) && cycle == CYC_ONE) begin
         next_popHigh = ramRdata;
      end
      if (lastCycle) begin
         unique case (opClass)
            CL_NEAR: begin
               next_programCounter = {returnAddr[15:12], op0[ADDR_HI_BIT], op0[2:0], op1};
            end
            CL_FAR_ABS: begin
               next_programCounter = {op1, op2};
            end
            CL_FAR_REL: begin
               next_programCounter = returnAddr - 16'h0001 + {op2, op1};
            end
            CL_RET: begin
               next_programCounter = {popHigh, ramRdata};
            end
            CL_IRQ_RET: begin
               next_programCounter = {popHigh, ramRdata};
               next_irqEnabled     = 1'b1;
            end
            CL_BIT_CLR, CL_BIT_SET, CL_BIT_INV, CL_NOP: begin
               next_programCounter = returnAddr;
            end
            CL_CHANGE: begin
               if (romMode) begin
                  next_romMode        = 1'b0;
                  next_flashBank      = FLASH_ENTRY_BNK;
                  next_programCounter = FLASH_ENTRY;
               end else if (!externalExecSelect) begin
                  next_romMode        = 1'b1;
                  next_programCounter = {op1, op2};
               end else begin
                  next_programCounter = {op1, op2};
               end
            end
            CL_NONE: begin
               next_programCounter = programCounter;
            end
            default: begin
               next_programCounter = programCounter;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state          <= ST_IDLE;
         cycle          <= 3'h0;
         op0            <= 8'h00;
         op1            <= 8'h00;
         op2            <= 8'h00;
         programCounter <= PC_RESET;
         popHigh        <= 8'h00;
         romMode        <= ROM_MODE_RESET;
         flashBank      <= FLASH_ENTRY_BNK;
         irqEnabled     <= 1'b1;
      end else begin
         state          <= next_state;
         cycle          <= next_cycle;
         op0            <= next_op0;
         op1            <= next_op1;
         op2            <= next_op2;
         programCounter <= next_programCounter;
         popHigh        <= next_popHigh;
         romMode        <= next_romMode;
         flashBank      <= next_flashBank;
         irqEnabled     <= next_irqEnabled;
      end
   end

   // checks on timing, stack traffic and mode switching
   a_near_timing: assert property (@(posedge mclk) disable iff (rst)
      accept && ((instrByte0 & NEAR_MASK) == NEAR_MATCH) |-> ##1 !execDone ##1 execDone)
      else $error("near call did not finish on its second cycle");

   a_near_target: assert property (@(posedge mclk) disable iff (rst)
      execDone && opClass == CL_NEAR |=>
         programCounter[15:12] == $past(returnAddr[15:12]) &&
         programCounter[11:0] == {$past(op0[4]), $past(op0[2:0]), $past(op1)})
      else $error("near call target wrong");

   a_push_order: assert property (@(posedge mclk) disable iff (rst)
      busy && cycle == CYC_ONE && (opClass == CL_FAR_ABS || opClass == CL_NEAR) |->
         ramWe && ramWdata == returnAddr[7:0] ##1
         ramWe && ramWdata == $past(returnAddr[15:8]) &&
         ramAddr == {1'b0, $past(stackPointer) + 8'h02})
      else $error("return address push order wrong");

   a_rel_window: assert property (@(posedge mclk) disable iff (rst)
      accept && instrByte0 == OP_FAR_REL |-> ##1 !irqWindow [*3] ##1 (irqWindow && execDone))
      else $error("relative call interrupt window not on fourth cycle");

   a_rel_target: assert property (@(posedge mclk) disable iff (rst)
      execDone && opClass == CL_FAR_REL |=>
         programCounter == $past(programCounter) + 16'h0002 + {$past(op2), $past(op1)})
      else $error("relative call target wrong");

   a_ret_pop: assert property (@(posedge mclk) disable iff (rst)
      busy && cycle == CYC_ONE && opClass == CL_RET |=>
         ramAddr == {1'b0, $past(stackPointer) - 8'h01} ##1
         stackPointer == $past(stackPointer, 2) - 8'h02)
      else $error("return pop sequence wrong");

   a_irq_return_quiet: assert property (@(posedge mclk) disable iff (rst)
      busy && (opClass == CL_IRQ_RET || opClass == CL_CHANGE) |-> !irqWindow)
      else $error("interrupt window open during interrupt return or mode change");

   a_irq_return_enable: assert property (@(posedge mclk) disable iff (rst)
      execDone && opClass == CL_IRQ_RET |=> irqEnabled)
      else $error("interrupt return did not re-enable interrupts");

   a_bit_clear: assert property (@(posedge mclk) disable iff (rst)
      busy && opClass == CL_BIT_CLR |->
         ramWe && execDone && !ramWdata[op0[2:0]] && ((ramWdata | bitMask) == (ramRdata | bitMask)))
      else $error("bit clear result wrong");

   a_mode_hold: assert property (@(posedge mclk) disable iff (rst)
      busy && !execDone |=> $stable(romMode))
      else $error("program space changed before the sequence finished");

   a_change_entry: assert property (@(posedge mclk) disable iff (rst)
      execDone && opClass == CL_CHANGE && romMode |=>
         !romMode && programCounter == FLASH_ENTRY && flashBank == FLASH_ENTRY_BNK)
      else $error("mode change from system program entered wrong place");
endmodule

// File: tb/sbx_ram_model.sv
// data ram and special register model on the executor's far side
// assumes one clock; reads answer in the same cycle, writes land at the edge
`timescale 1ns/1ns
module sbx_ram_model (
   input  wire logic       mclk,
   input  wire logic [8:0] ramAddr,
   input  wire logic       ramRe,
   input  wire logic       ramWe,
   input  wire logic [7:0] ramWdata,
   output logic      [7:0] ramRdata
);
   logic [7:0] mem [512];
   logic [7:0] lastRd;

   initial lastRd = 8'h5a;

   // unselected port shows the inverse of the last value, never stale data
   assign ramRdata = ramRe ? mem[ramAddr] : ~lastRd;

   // writes and read history update at the edge ending the cycle
   always @(posedge mclk) begin
      if (ramWe) mem[ramAddr] <= ramWdata;
      if (ramRe) lastRd <= mem[ramAddr];
   end
endmodule

// File: tb/subroutine_bit_ops_exec_tb.sv
// self-checking bench for the call, return, bit, no-op and mode-change executor
// assumes the ram model answers reads combinationally; one 100 MHz clock
`timescale 1ns/1ns
module subroutine_bit_ops_exec_tb import sbx_pkg::*;;
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0]  sp;
      logic        iw, il, rm, rc;
      logic [8:0]  ra;
      logic [7:0]  rv;
   } sbx_note_t;
   logic        mclk, rst, execStart, extSel, irqTaken, spLoad;
   logic [7:0]  instrByte0, instrByte1, instrByte2, spLoadValue, ramRdata, ramWdata;
   logic        busy, execDone, illegalOp, irqWindow, irqEnabled, romMode, flashBank;
   logic        ramRe, ramWe;
   logic [15:0] programCounter, ePc;
   logic [7:0]  stackPointer, eSp, op, b1, rv;
   logic [8:0]  ramAddr, ra;
   logic        eRm;
   sbx_note_t   q[$];
   sbx_note_t   n;
   int          mismatches, samples_checked, cycles;
   int          seed = 32'hfa545019;

   subroutine_bit_ops_exec subroutine_bit_ops_exec_inst (.mclk(mclk), .rst(rst),
      .execStart(execStart), .instrByte0(instrByte0), .instrByte1(instrByte1),
      .instrByte2(instrByte2), .externalExecSelect(extSel), .irqTaken(irqTaken),
      .spLoad(spLoad), .spLoadValue(spLoadValue), .ramRdata(ramRdata), .busy(busy),
      .execDone(execDone), .illegalOp(illegalOp), .irqWindow(irqWindow),
      .irqEnabled(irqEnabled), .programCounter(programCounter), .stackPointer(stackPointer),
      .romMode(romMode), .flashBank(flashBank), .ramAddr(ramAddr), .ramRe(ramRe),
      .ramWe(ramWe), .ramWdata(ramWdata));
   sbx_ram_model sbx_ram_model_inst (.mclk(mclk), .ramAddr(ramAddr), .ramRe(ramRe),
      .ramWe(ramWe), .ramWdata(ramWdata), .ramRdata(ramRdata));

   // clock and hang guard
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         results();
      end
   end

   // compare one value and count it
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // issue one instruction and note what it must leave behind
   task automatic run(input logic [7:0] b0, c1, c2, input logic iw, il, rc,
                      input logic [8:0] a, input logic [7:0] v);
      logic [2:0] cy;
      logic [2:0] k;
      cy = CYC_ONE;
      if (b0 == OP_FAR_REL) cy = CYC_FOUR;
      else if (b0 == OP_FAR_ABS || b0 == OP_RET || b0 == OP_IRQ_RET) cy = CYC_TWO;
      else if (b0 == OP_CHANGE_DEF || (b0 & NEAR_MASK) == NEAR_MATCH) cy = CYC_TWO;
      k = 3'h0;
      q.push_back('{ePc, eSp, iw, il, eRm, rc, a, v});
      @(posedge mclk);
      execStart <= 1'b1;
      instrByte0 <= b0;
      instrByte1 <= c1;
      instrByte2 <= c2;
      @(posedge mclk);
      execStart <= 1'b0;
      // count busy cycles up to the completion pulse
      do begin
         @(negedge mclk);
         if (busy === 1'b1) k = k + 3'h1;
      end while (execDone !== 1'b1);
      chk("cycles", k, cy);
      // step past the closing edge so its updates have landed
      @(posedge mclk);
      #1;
   endtask

   // software load of the stack pointer while idle
   task automatic ldsp(input logic [7:0] v);
      @(posedge mclk);
      spLoad <= 1'b1;
      spLoadValue <= v;
      @(posedge mclk);
      spLoad <= 1'b0;
   endtask

   task automatic results;
      if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // watcher: take the oldest note whenever a completion shows
   always @(negedge mclk) begin
      if (execDone === 1'b1) begin
         if (q.size() == 0) mismatches++;
         else begin
            n = q.pop_front();
            chk("illegalOp", illegalOp, n.il);
            if (!n.il) chk("irqWindow", irqWindow, n.iw);
            @(posedge mclk);
            #1;
            chk("programCounter", programCounter, n.pc);
            chk("stackPointer", stackPointer, n.sp);
            chk("romMode", romMode, n.rm);
            chk("flashBank", flashBank, 16'h0000);
            if (n.rc) chk("bitop ram", sbx_ram_model_inst.mem[n.ra], n.rv);
         end
      end
   end

   // main sequence
   initial begin
      mclk = 0; rst = 1; execStart = 0; extSel = 0; irqTaken = 0; spLoad = 0;
      instrByte0 = 0; instrByte1 = 0; instrByte2 = 0; spLoadValue = 0; eRm = 1;
      for (int i = 0; i < 512; i++) sbx_ram_model_inst.mem[i] = $random(seed);
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      ldsp(8'h1f);
      ePc = 16'h0ffd; eSp = 8'h21;
      run(OP_FAR_ABS, 8'h0f, 8'hfd, 1, 0, 0, 0, 0);
      chk("push lo", sbx_ram_model_inst.mem[9'h020], 16'h0003);
      ldsp(8'h1f);
      ePc = 16'h0f0e;
      run(8'h1f, 8'h0e, $random(seed), 1, 0, 0, 0, 0);
      chk("push lo", sbx_ram_model_inst.mem[9'h020], 16'h00ff);
      chk("push hi", sbx_ram_model_inst.mem[9'h021], 16'h000f);
      ePc = 16'h0fff; eSp = 8'h1f;
      run(OP_RET, $random(seed), $random(seed), 1, 0, 0, 0, 0);
      ePc = 16'h1202; eSp = 8'h21;
      run(OP_FAR_REL, 8'h01, 8'h02, 1, 0, 0, 0, 0);
      chk("push hi", sbx_ram_model_inst.mem[9'h021], 16'h0010);
      @(posedge mclk);
      irqTaken <= 1'b1;
      @(posedge mclk);
      irqTaken <= 1'b0;
      @(negedge mclk);
      chk("irqEnabled", irqEnabled, 16'h0000);
      ePc = 16'h1002; eSp = 8'h1f;
      run(OP_IRQ_RET, 8'h00, 8'h00, 0, 0, 0, 0, 0);
      chk("irqEnabled", irqEnabled, 16'h0001);
      ldsp(8'hff);
      ePc = 16'h1000; eSp = 8'h01;
      run(8'h08, 8'h00, 8'h00, 1, 0, 0, 0, 0);
      chk("wrap lo", sbx_ram_model_inst.mem[9'h000], 16'h0004);
      ePc = 16'h1004; eSp = 8'hff;
      run(OP_RET, 8'h00, 8'h00, 1, 0, 0, 0, 0);
      for (int i = 0; i < 12; i++) begin
         @(negedge mclk);
         op = (i % 3 == 0) ? BIT_CLR_MATCH : (i % 3 == 1) ? BIT_SET_MATCH : BIT_INV_MATCH;
         op = op | (8'($random(seed)) & 8'h17);
         b1 = $random(seed);
         ra = {op[4], b1};
         rv = sbx_ram_model_inst.mem[ra];
         if (i % 3 == 0) rv = rv & ~(8'h01 << op[2:0]);
         else if (i % 3 == 1) rv = rv | (8'h01 << op[2:0]);
         else rv = rv ^ (8'h01 << op[2:0]);
         ePc = ePc + 16'h0002;
         run(op, b1, $random(seed), 1, 0, 1, ra, rv);
      end
      ePc = ePc + 16'h0001;
      run(OP_NOP, $random(seed), $random(seed), 1, 0, 0, 0, 0);
      run(8'h02, 8'h00, 8'h00, 0, 1, 0, 0, 0);
      eRm = 0; ePc = 16'h0000;
      run(OP_CHANGE_DEF, 8'h12, 8'h34, 0, 0, 0, 0, 0);
      eRm = 1; ePc = 16'h0456;
      run(OP_CHANGE_DEF, 8'h04, 8'h56, 0, 0, 0, 0, 0);
      eRm = 0; ePc = 16'h0000;
      run(OP_CHANGE_DEF, 8'h0a, 8'hbc, 0, 0, 0, 0, 0);
      @(posedge mclk);
      extSel <= 1'b1;
      ePc = 16'h0789;
      run(OP_CHANGE_DEF, 8'h07, 8'h89, 0, 0, 0, 0, 0);
      repeat (3) @(posedge mclk);
      results();
   end
endmodule
